// >>> logic/smf_mode_ctrl.v
// Operating-mode state machine and hardware failure configuration of the SBC.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "smf_map.vh"
// What this block does
// - Exactly six modes, one current mode at a time.
// - Enter init after power-up and after software soft reset.
// - Stop mode keeps the main regulator on.
// - Sleep mode turns the main regulator off.
// - Restart on wake or failure, asserts reset, then normal after delay.
// - Fail-safe turns regulator off until wake or overtemperature clears.
// - Development mode reaches all modes but halts the watchdog.
// - Debug pin low during init selects development mode.
// - All configuration and diagnosis uses 16-bit serial frames; here they arrive as 16-bit words on the register port.
// - Mode field write changes mode; restart clears it to show mode.
// - Power-on starts init with watchdog long open window.
// - During reset delay pull interrupt pin low and filter its level.
// - Latch filtered interrupt level as pin config on reset rising edge.
// - While power-on flag set, re-pull and re-latch at every reset pulse.
// - Unstable interrupt level during sampling stores zero.
// - Pin config and fail-count select give four configurations.
// - Pin config 1: watchdog failure restarts; fail outputs after 1st or 2nd.
// - Pin config 0: fail-safe; config 4 first failure restarts instead.
// - Overvoltage with enable sets flag, fail outputs, restart or fail-safe.
// - Software reads fail-count select and pin config bits.
// - Any serial command in init moves to normal.
// - No trigger in long open window during init gives failure, restart.
// - Latched configuration kept until power-on reset.
module smf_mode_ctrl #(
    parameter CFG_FILTER_CYC = (`SMF_CFG_FILTER_NS + `SMF_CLK_NS - 1) / `SMF_CLK_NS,
    // A bench may shorten these counts; the defaults are the full times at 40 MHz.
    parameter RESET_DELAY_CYC = (`SMF_RESET_DELAY_NS + `SMF_CLK_NS - 1) / `SMF_CLK_NS,
    parameter LONG_WINDOW_CYC = `SMF_LONG_WINDOW_NS / `SMF_CLK_NS
) (
    input wire clock_i,
    input wire reset_i,
    input wire [3:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    input wire spi_frame_i,
    input wire wd_trigger_i,
    input wire wd_fail_i,
    input wire overvoltage_i,
    input wire wake_i,
    input wire overtemp_i,
    input wire int_pin_i,
    input wire debug_sel_i,
    output reg [15:0] reg_rdata_o,
    output reg [2:0] mode_o,
    output reg main_reg_en_o,
    output reg reset_output_o,
    output reg int_pull_down_o,
    output reg fail_outputs_o,
    output reg wd_halt_o
);

// ----------------------------------------------------------------
// Synchronisers for asynchronous pins
// ----------------------------------------------------------------
// Each pin costs two cycles of latency before any reaction.
// That is far below every time the block has to meet, so nothing is lost.
reg [6:0] sync1_r;
reg [6:0] sync2_r;
wire int_s = sync2_r[0];
wire dbg_s = sync2_r[1];
wire ov_s = sync2_r[2];
wire wake_s = sync2_r[3];
wire ot_s = sync2_r[4];
wire wdf_s = sync2_r[5];
wire trg_s = sync2_r[6];

always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
        // The debug pin idles high; clearing it would fake development mode at release.
        // Every other pin idles low, so the edge detectors see no false edge after reset.
        sync1_r <= 7'h02;
        sync2_r <= 7'h02;
    end else begin
        sync1_r <= {wd_trigger_i, wd_fail_i, overtemp_i, wake_i, overvoltage_i,
                    debug_sel_i, int_pin_i};
        sync2_r <= sync1_r;
    end
end

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
// The delay and window counters are 32 bits wide so that the full default times fit.
// The delay counter stops at its end value instead of wrapping, so a long stay in
// one mode can never make the reset output fall again by itself.
reg [2:0] mode_r;
reg [2:0] mode_nxt;
reg [31:0] delay_cnt_r;
reg [31:0] win_cnt_r;
reg [15:0] filt_cnt_r;
reg filt_lvl_r;
reg filt_stable_r;
reg pin_cfg_r;
reg cfg_sel_r;
reg ov_rst_en_r;
reg por_flag_r;
reg ov_flag_r;
reg dev_mode_r;
reg wd_fail_seen_r;
reg wdf_d_r;
reg ov_d_r;
reg rst_out_d_r;
reg in_rd_r;

// ----------------------------------------------------------------
// Decoding helpers
// ----------------------------------------------------------------
// These decodes are shared by several processes.
// Keeping each in one place stops the copies from drifting apart.

// True while the next mode is init or restart and the reset delay has not run out.
// A change of mode counts as the first cycle of a fresh delay.
function reset_hold;
    input [2:0] next_mode;
    input [2:0] cur_mode;
    input [31:0] count;
    begin
        reset_hold = (next_mode == `SMF_MODE_INIT || next_mode == `SMF_MODE_RESTART) &&
                     (next_mode != cur_mode || count < RESET_DELAY_CYC - 1);
    end
endfunction

// Decodes one register index on a strobe; every write path goes through it, while reads decode the address in their own case.
function reg_hit;
    input strobe;
    input [3:0] addr;
    input [3:0] index;
    begin
        reg_hit = strobe && (addr == index);
    end
endfunction

// Sleep and fail-safe both drop the main regulator and hold the controller in reset.
function power_off;
    input [2:0] mode;
    begin
        power_off = (mode == `SMF_MODE_SLEEP) || (mode == `SMF_MODE_FAILSAFE);
    end
endfunction

wire mode_wr = reg_hit(reg_write_i, reg_addr_i, `SMF_ADDR_MODE_CTRL);
// A soft reset rides on a mode write, so it is refused nowhere.
wire soft_rst = mode_wr && reg_wdata_i[`SMF_MC_SOFTRST_BIT];
wire hw_wr = reg_hit(reg_write_i, reg_addr_i, `SMF_ADDR_HARDWARE_CONTROL_REG);
wire status_wr = reg_hit(reg_write_i, reg_addr_i, `SMF_ADDR_STATUS);
// Reset stays low through the delay in init and restart, and in the off states.
wire rst_hold = reset_hold(mode_nxt, mode_r, delay_cnt_r) || power_off(mode_nxt);
wire cfg_window = por_flag_r && reset_hold(mode_nxt, mode_r, delay_cnt_r);
wire win_expired = (mode_r == `SMF_MODE_INIT) && !dev_mode_r &&
                   (win_cnt_r >= LONG_WINDOW_CYC - 1);
wire wd_event = ((wdf_s && !wdf_d_r) && !dev_mode_r) || win_expired;
wire ov_event = ov_s && !ov_d_r && ov_rst_en_r;
// The four configurations of pin level and fail-count select:
// pin 1, select 1: restart, fail outputs on the first failure.
// pin 0, select 1: fail-safe, fail outputs on the first failure.
// pin 1, select 0: restart, fail outputs on the second failure.
// pin 0, select 0: restart first, then fail-safe and fail outputs on the second.
// First failure in config 4 goes to restart; every other pin 0 case goes fail-safe.
wire wd_to_fs = !pin_cfg_r && (cfg_sel_r || wd_fail_seen_r);

// ----------------------------------------------------------------
// Mode selection
// ----------------------------------------------------------------
// Priority, lowest first: the mode's own exits, a watchdog failure, an overvoltage,
// and a soft reset. The off states ignore failures because the controller is
// unpowered there and cannot have caused them.
always @* begin
    mode_nxt = mode_r;
    case (mode_r)
        `SMF_MODE_INIT: begin
            if (spi_frame_i || mode_wr) begin
                mode_nxt = `SMF_MODE_NORMAL;
            end
        end
        `SMF_MODE_NORMAL, `SMF_MODE_STOP: begin
            if (mode_wr) begin
                // Stop cannot go straight to sleep; that request falls back to restart.
                case (reg_wdata_i[2:0])
                    `SMF_MODE_NORMAL: mode_nxt = `SMF_MODE_NORMAL;
                    `SMF_MODE_STOP: mode_nxt = `SMF_MODE_STOP;
                    `SMF_MODE_SLEEP: mode_nxt = (mode_r == `SMF_MODE_STOP) ?
                                                 `SMF_MODE_RESTART : `SMF_MODE_SLEEP;
                    default: mode_nxt = mode_r;
                endcase
            end
        end
        `SMF_MODE_SLEEP: begin
            if (wake_s) begin
                mode_nxt = `SMF_MODE_RESTART;
            end
        end
        `SMF_MODE_RESTART: begin
            if (delay_cnt_r >= RESET_DELAY_CYC - 1 && !wdf_s && !ov_s) begin
                mode_nxt = `SMF_MODE_NORMAL;
            end
        end
        `SMF_MODE_FAILSAFE: begin
            // Fail-safe is left as soon as a wake arrives or the overtemperature is gone.
            if (wake_s || !ot_s) begin
                mode_nxt = `SMF_MODE_RESTART;
            end
        end
        default: mode_nxt = `SMF_MODE_INIT;
    endcase
    if (!power_off(mode_r)) begin
        if (wd_event) begin
            mode_nxt = wd_to_fs ? `SMF_MODE_FAILSAFE : `SMF_MODE_RESTART;
        end
        if (ov_event) begin
            mode_nxt = pin_cfg_r ? `SMF_MODE_RESTART : `SMF_MODE_FAILSAFE;
        end
    end
    if (soft_rst) begin
        mode_nxt = `SMF_MODE_INIT;
    end
end

// ----------------------------------------------------------------
// Mode register, timers and failure bookkeeping
// ----------------------------------------------------------------
// The failure count only remembers whether one failure has been seen; that is all
// the four configurations need, and it keeps the counter to a single flag.
// Fail outputs are sticky until power-on reset.
always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
        mode_r <= `SMF_MODE_INIT;
        delay_cnt_r <= 32'h0;
        win_cnt_r <= 32'h0;
        wd_fail_seen_r <= 1'b0;
        fail_outputs_o <= 1'b0;
        ov_flag_r <= 1'b0;
        wdf_d_r <= 1'b0;
        ov_d_r <= 1'b0;
    end else begin
        mode_r <= mode_nxt;
        wdf_d_r <= wdf_s;
        ov_d_r <= ov_s;
        // Restart and init both hold reset low for the reset delay time.
        if (mode_nxt != mode_r) begin
            delay_cnt_r <= 32'h0;
        end else if (delay_cnt_r < RESET_DELAY_CYC) begin
            delay_cnt_r <= delay_cnt_r + 32'h1;
        end
        if (mode_r != `SMF_MODE_INIT || trg_s || mode_nxt != mode_r) begin
            win_cnt_r <= 32'h0;
        end else if (!dev_mode_r) begin
            win_cnt_r <= win_cnt_r + 32'h1;
        end
        if (wd_event) begin
            wd_fail_seen_r <= 1'b1;
            if (cfg_sel_r || wd_fail_seen_r) begin
                fail_outputs_o <= 1'b1;
            end
        end
        if (ov_event) begin
            fail_outputs_o <= 1'b1;
        end
        // A new overvoltage wins over a clear in the same cycle.
        if (ov_s && !ov_d_r) begin
            ov_flag_r <= 1'b1;
        end else if (status_wr && reg_wdata_i[`SMF_ST_OV_BIT]) begin
            ov_flag_r <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Configuration sampling on the interrupt pin
// ----------------------------------------------------------------
// A level change restarts the filter count, so only a level that holds for the
// whole filter time counts as stable. An unstable pin latches zero, the safe choice.
// Development mode can only be entered, never left, until the next power-on.
always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
        filt_cnt_r <= 16'h0;
        filt_lvl_r <= 1'b0;
        filt_stable_r <= 1'b0;
        pin_cfg_r <= 1'b0;
        dev_mode_r <= 1'b0;
        por_flag_r <= 1'b1;
        rst_out_d_r <= 1'b0;
    end else begin
        rst_out_d_r <= reset_output_o;
        if (!in_rd_r) begin
            filt_cnt_r <= 16'h0;
            filt_stable_r <= 1'b0;
        end else if (int_s != filt_lvl_r) begin
            filt_lvl_r <= int_s;
            filt_cnt_r <= 16'h0;
            filt_stable_r <= 1'b0;
        end else if (filt_cnt_r >= CFG_FILTER_CYC[15:0] - 16'h1) begin
            filt_stable_r <= 1'b1;
        end else begin
            filt_cnt_r <= filt_cnt_r + 16'h1;
        end
        if (reset_output_o && !rst_out_d_r && por_flag_r) begin
            pin_cfg_r <= filt_stable_r & filt_lvl_r;
        end
        if (mode_r == `SMF_MODE_INIT && !dbg_s) begin
            dev_mode_r <= 1'b1;
        end
        if (status_wr && reg_wdata_i[`SMF_ST_POR_BIT]) begin
            por_flag_r <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
// Every pin set here except wd_halt_o is registered from the next mode, so the outputs change on the same
// edge as the mode register and never glitch while the mode decode settles.
always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
        mode_o <= `SMF_MODE_INIT;
        main_reg_en_o <= 1'b1;
        reset_output_o <= 1'b0;
        int_pull_down_o <= 1'b0;
        in_rd_r <= 1'b0;
        wd_halt_o <= 1'b0;
    end else begin
        mode_o <= mode_nxt;
        main_reg_en_o <= !power_off(mode_nxt);
        reset_output_o <= !rst_hold;
        // The filter runs exactly while the pull-down is on, but through the synchroniser its first two samples still come from before it.
        in_rd_r <= cfg_window;
        int_pull_down_o <= cfg_window;
        wd_halt_o <= dev_mode_r;
    end
end

// ----------------------------------------------------------------
// Register port
// ----------------------------------------------------------------
// Read data stand for one cycle only and are zero otherwise, so a stray sample
// by the controller never picks up a stale value.
always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
        cfg_sel_r <= 1'b0;
        ov_rst_en_r <= 1'b0;
        reg_rdata_o <= 16'h0000;
    end else begin
        if (hw_wr) begin
            cfg_sel_r <= reg_wdata_i[`SMF_HW_CFG_BIT];
            ov_rst_en_r <= reg_wdata_i[`SMF_HW_OVRST_BIT];
        end
        reg_rdata_o <= 16'h0000;
        if (reg_read_i) begin
            case (reg_addr_i)
                `SMF_ADDR_MODE_CTRL: reg_rdata_o <= {13'h0000, mode_r};
                `SMF_ADDR_HARDWARE_CONTROL_REG: reg_rdata_o <= {14'h0000, ov_rst_en_r, cfg_sel_r};
                `SMF_ADDR_WAKE_LVL: reg_rdata_o <= {15'h0000, pin_cfg_r};
                `SMF_ADDR_STATUS: reg_rdata_o <= {12'h000, dev_mode_r, wd_fail_seen_r,
                                                   ov_flag_r, por_flag_r};
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end
end

endmodule // smf_mode_ctrl

// >>> logic/smf_map.vh
// Constants for the SBC mode and failure configuration block.
`ifndef SMF_MAP_VH
`define SMF_MAP_VH
// Register indexes on the plain register port.
`define SMF_ADDR_MODE_CTRL 4'h0
`define SMF_ADDR_HARDWARE_CONTROL_REG 4'h1
`define SMF_ADDR_WAKE_LVL 4'h2
`define SMF_ADDR_STATUS 4'h3
// Mode codes held in the mode field.
`define SMF_MODE_INIT 3'h0
`define SMF_MODE_NORMAL 3'h1
`define SMF_MODE_STOP 3'h2
`define SMF_MODE_SLEEP 3'h3
`define SMF_MODE_RESTART 3'h4
`define SMF_MODE_FAILSAFE 3'h5
// Field positions.
`define SMF_MC_SOFTRST_BIT 3
`define SMF_HW_CFG_BIT 0
`define SMF_HW_OVRST_BIT 1
`define SMF_WL_PIN_CONFIG_LEVEL_BIT 0
`define SMF_ST_POR_BIT 0
`define SMF_ST_OV_BIT 1
`define SMF_ST_WDF_BIT 2
`define SMF_ST_DEV_BIT 3
// Reset values.
`define SMF_HARDWARE_CONTROL_REG_RST 2'h0
// Timing in nanoseconds and clock period.
`define SMF_CLK_NS 25
`define SMF_CFG_FILTER_NS 10000
`define SMF_RESET_DELAY_NS 10000000
`define SMF_LONG_WINDOW_NS 200000000
`define SMF_SPI_FRAME_BITS 16
`endif

// >>> verif/smf_mode_ctrl_sva.sv
// Assertion checker for the SBC mode and failure configuration block.
`timescale 1ns/1ps
`include "smf_map.vh"
module smf_mode_ctrl_chk (
    input wire clock_i,
    input wire reset_i,
    input wire [3:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    input wire spi_frame_i,
    input wire [15:0] reg_rdata_o,
    input wire [2:0] mode_o,
    input wire main_reg_en_o,
    input wire reset_output_o,
    input wire int_pull_down_o,
    input wire fail_outputs_o,
    input wire wd_halt_o
);
    // ------------------------------------------------------------
    // Mode and output relations
    // ------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_mode_legal: assert property (
        mode_o <= `SMF_MODE_FAILSAFE) else $error("mode code out of range");
    a_stop_reg_on: assert property (
        mode_o == `SMF_MODE_STOP |-> main_reg_en_o) else $error("regulator off in stop");
    a_sleep_reg_off: assert property (
        (mode_o == `SMF_MODE_SLEEP)[*2] |-> !main_reg_en_o) else $error("regulator on in sleep");
    a_failsafe_reg_off: assert property (
        (mode_o == `SMF_MODE_FAILSAFE)[*2] |-> !main_reg_en_o)
        else $error("regulator on in fail-safe");
    a_init_cmd_normal: assert property (
        mode_o == `SMF_MODE_INIT && spi_frame_i |-> ##[1:3] mode_o == `SMF_MODE_NORMAL)
        else $error("command in init did not reach normal");
    a_stop_sleep_restart: assert property (
        mode_o == `SMF_MODE_STOP && reg_write_i && reg_addr_i == `SMF_ADDR_MODE_CTRL
        && reg_wdata_i[2:0] == `SMF_MODE_SLEEP |=> mode_o == `SMF_MODE_RESTART)
        else $error("stop to sleep did not restart");
    a_restart_reset_low: assert property (
        $rose(mode_o == `SMF_MODE_RESTART) |-> ##2 !reset_output_o)
        else $error("reset output high in restart");
    // One cycle of lag is allowed since both outputs are registered.
    a_pull_reset_low: assert property (
        reset_output_o && $past(reset_output_o) |-> !int_pull_down_o)
        else $error("pull-down with reset released");
    a_fail_sticky: assert property (
        fail_outputs_o |=> fail_outputs_o) else $error("fail outputs dropped");
    a_halt_sticky: assert property (
        wd_halt_o |=> wd_halt_o) else $error("watchdog halt dropped");
    a_rdata_idle: assert property (
        !$past(reg_read_i) |-> reg_rdata_o == 16'h0) else $error("read data without read");
endmodule // smf_mode_ctrl_chk
bind smf_mode_ctrl smf_mode_ctrl_chk chk_u (.*);

// >>> verif/smf_mcu_model.sv
// Microcontroller model: serial command sender and interrupt pin wiring.
`timescale 1ns/1ps
module smf_mcu_model (
    input wire clock_i,
    input wire send_i,
    input wire pull_up_i,
    input wire pull_dn_i,
    output logic frame_o,
    output wire int_pin_o
);
    // ------------------------------------------------------------
    // Pin and frame behaviour
    // ------------------------------------------------------------
    logic float_r = 1'b0;
    initial frame_o = 1'b0;
    always @(posedge clock_i) float_r <= ~float_r;
    // A fitted pull-up beats the weak pull-down; an undriven pin wanders.
    assign int_pin_o = pull_up_i ? 1'b1 : (pull_dn_i ? 1'b0 : float_r);
    // A command is sixteen link clocks of 200 ns before the frame strobe.
    always @(posedge send_i) begin
        repeat (16) #200;
        @(posedge clock_i) frame_o <= 1'b1;
        @(posedge clock_i) frame_o <= 1'b0;
    end
endmodule // smf_mcu_model

// >>> verif/tb_top.sv
// Self-checking bench for the SBC mode and failure configuration block.
`timescale 1ns/1ps
`include "smf_map.vh"
module tb_top;
    // ------------------------------------------------------------
    // Stimulus, instances and helpers
    // ------------------------------------------------------------
    logic clock_i = 0, reset_i = 1, reg_write_i = 0, reg_read_i = 0, wd_trigger_i = 0;
    logic wd_fail_i = 0, overvoltage_i = 0, wake_i = 0, overtemp_i = 0, debug_sel_i = 1;
    logic send = 0, pull_up = 1;
    logic [3:0] reg_addr_i = 0;
    logic [15:0] reg_wdata_i = 0;
    wire [15:0] reg_rdata_o;
    wire [2:0] mode_o;
    wire spi_frame_i, int_pin_i, main_reg_en_o, reset_output_o;
    wire int_pull_down_o, fail_outputs_o, wd_halt_o;
    int n_mismatch = 0, n_compared = 0;
    always #12.5 clock_i = ~clock_i;
    smf_mode_ctrl #(.CFG_FILTER_CYC(4), .RESET_DELAY_CYC(20), .LONG_WINDOW_CYC(200)) dut_u (.*);
    smf_mcu_model mcu_u (.clock_i(clock_i), .send_i(send), .pull_up_i(pull_up),
        .pull_dn_i(int_pull_down_o), .frame_o(spi_frame_i), .int_pin_o(int_pin_i));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wm(logic [2:0] m, int lim);
        repeat (lim) if (mode_o !== m) @(negedge clock_i);
        chk("mode", {13'h0, m}, {13'h0, mode_o});
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clock_i) {reg_addr_i, reg_wdata_i, reg_write_i} <= {a, d, 1'b1};
        @(posedge clock_i) reg_write_i <= 1'b0;
    endtask
    task automatic rc(string what, logic [3:0] a, logic [15:0] msk, logic [15:0] exp);
        @(posedge clock_i) {reg_addr_i, reg_read_i} <= {a, 1'b1};
        @(posedge clock_i) reg_read_i <= 1'b0;
        @(negedge clock_i) chk(what, exp, reg_rdata_o & msk);
    endtask
    task automatic por(logic pu, logic dbg);
        @(posedge clock_i) {reset_i, pull_up, debug_sel_i} <= {1'b1, pu, dbg};
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        @(negedge clock_i) chk("init", 16'h0, {13'h0, mode_o});
        repeat (60) if (!reset_output_o) @(negedge clock_i);
        chk("reset released", 16'h1, {15'h0, reset_output_o});
    endtask
    task automatic wdf(logic [2:0] m, logic f);
        wm(`SMF_MODE_NORMAL, 80);
        @(posedge clock_i) wd_fail_i <= 1'b1;
        wm(m, 8);
        @(posedge clock_i) wd_fail_i <= 1'b0;
        repeat (4) @(negedge clock_i);
        chk("fail outputs", {15'h0, f}, {15'h0, fail_outputs_o});
    endtask
    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_config3;
        por(1'b1, 1'b1);
        rc("pin config", 4'h2, 16'h1, 16'h1);
        rc("unmapped", 4'h9, 16'hffff, 16'h0);
        @(posedge clock_i) send <= 1'b1;
        wm(`SMF_MODE_NORMAL, 200);
        send <= 1'b0;
        wr(4'h0, {13'h0, `SMF_MODE_STOP});
        wm(`SMF_MODE_STOP, 4);
        chk("stop regulator", 16'h1, {15'h0, main_reg_en_o});
        wr(4'h0, {13'h0, `SMF_MODE_SLEEP});
        wm(`SMF_MODE_RESTART, 4);
        wm(`SMF_MODE_NORMAL, 80);
        rc("mode field", 4'h0, 16'h7, {13'h0, `SMF_MODE_NORMAL});
        wr(4'h0, {13'h0, `SMF_MODE_SLEEP});
        wm(`SMF_MODE_SLEEP, 4);
        repeat (2) @(negedge clock_i);
        chk("sleep regulator", 16'h0, {15'h0, main_reg_en_o});
        @(posedge clock_i) wake_i <= 1'b1;
        wm(`SMF_MODE_RESTART, 8);
        @(posedge clock_i) wake_i <= 1'b0;
        wdf(`SMF_MODE_RESTART, 1'b0);
        wdf(`SMF_MODE_RESTART, 1'b1);
        wm(`SMF_MODE_NORMAL, 80);
        wr(4'h1, 16'h2);
        rc("hardware control", 4'h1, 16'h3, 16'h2);
        @(posedge clock_i) overvoltage_i <= 1'b1;
        wm(`SMF_MODE_RESTART, 8);
        @(posedge clock_i) overvoltage_i <= 1'b0;
        rc("overvoltage flag", 4'h3, 16'h2, 16'h2);
        $display("test config3 done");
    endtask
    task automatic t_config4;
        por(1'b0, 1'b1);
        rc("pin config", 4'h2, 16'h1, 16'h0);
        wm(`SMF_MODE_RESTART, 300);
        chk("fail outputs", 16'h0, {15'h0, fail_outputs_o});
        // Overtemperature is held so that fail-safe cannot be left early.
        @(posedge clock_i) overtemp_i <= 1'b1;
        wdf(`SMF_MODE_FAILSAFE, 1'b1);
        chk("fail-safe regulator", 16'h0, {15'h0, main_reg_en_o});
        @(posedge clock_i) overtemp_i <= 1'b0;
        wm(`SMF_MODE_RESTART, 8);
        $display("test config4 done");
    endtask
    task automatic t_devmode;
        por(1'b1, 1'b0);
        chk("watchdog halt", 16'h1, {15'h0, wd_halt_o});
        @(posedge clock_i) send <= 1'b1;
        wm(`SMF_MODE_NORMAL, 200);
        send <= 1'b0;
        wr(4'h0, 16'h8);
        wm(`SMF_MODE_INIT, 4);
        $display("test devmode done");
    endtask
    initial begin
        t_config3;
        t_config4;
        t_devmode;
        close_out;
    end
    initial begin
        #200us;
        n_mismatch++;
        close_out;
    end
endmodule // tb_top
